// ==== hw/fsr_regs.vh ====
`ifndef FSR_REGS_VH
`define FSR_REGS_VH
// ----------------------------------------
// opcodes
// ----------------------------------------
`define FSR_OP_RD_STATUS 8'h05
`define FSR_OP_WR_STATUS 8'h01
`define FSR_OP_WR_STATUS2 8'h31
`define FSR_OP_WR_ENABLE 8'h06
`define FSR_OP_WR_DISABLE 8'h04
// ----------------------------------------
// status byte one fields
// ----------------------------------------
`define FSR_B1_LOCK 7
`define FSR_B1_ERR 5
`define FSR_B1_PIN 4
`define FSR_B1_PROT 2
`define FSR_B1_WEL 1
`define FSR_B1_BUSY 0
// ----------------------------------------
// status byte two fields
// ----------------------------------------
`define FSR_B2_RESET_COMMAND_ENABLE 4
`define FSR_B2_BUSY 0
// ----------------------------------------
// counts and reset values
// ----------------------------------------
`define FSR_BIT_LAST 3'h7
`define FSR_BITS_ZERO 3'h0
`define FSR_BYTE_ZERO 8'h00
`define FSR_OPC_BYTE 2'h0
`define FSR_DATA_BYTE 2'h1
`define FSR_EXTRA_BYTE 2'h2
`endif

// ==== hw/fsr_status.v ====
// Functional notes
// - after read opcode, shift from byte-1 bit 7
// - after byte-2 bit 0, wrap to byte 1
// - every repetition samples live status
// - status read accepted even while busy
// - chip select release stops read, tristates output
// - byte one layout; bits 6,3 zero
// - write-status changes only bits 7 and 2
// - lock plus pin asserted freezes array protect
// - lock zero frees protect; lock resets zero
// - pin asserted: lock may only rise
// - failed erase/program sets error flag
// - error updated per operation, not on abort
// - pin mirror reads 0 when pin asserted
// - protect one blocks all program/erase
// - latch zero rejects writing commands
// - latch zero after power-up and reset
// - latch cleared on listed completions, aborts, hold
// - partial or unknown opcode leaves latch
// - busy flag one while operation runs
// - byte two: reset enable bit4, busy bit0
// - write-status data applied at chip select release
`timescale 1ns/100ps
`include "fsr_regs.vh"
module fsr_status (
    input wire clk_sys_in,          // 200 MHz system clock
    input wire rst_b_in,            // async reset, active low
    input wire sck_in,              // serial clock pin
    input wire cs_b_in,             // chip select pin, active low
    input wire si_in,               // serial data in pin
    input wire wp_b_in,             // write protect pin, active low
    input wire op_busy_in,          // internal operation running
    input wire op_done_in,          // pulse: erase/program finished
    input wire op_fail_in,          // with done: a byte failed
    input wire op_abort_in,         // pulse: erase/program/otp aborted
    input wire dev_reset_in,        // pulse: device reset operation
    input wire hold_abort_in,       // pulse: hold condition aborted
    output reg so_out,              // serial data out
    output reg so_oe_out,           // serial out enable
    output reg array_protect_out,   // whole array protected
    output reg write_enable_latch_out, // write latch state
    output reg reset_command_enable_out, // reset command enabled
    output reg opcode_out,          // pulse: full opcode received
    output reg [7:0] opcode_val_out // last full opcode
);
// ----------------------------------------
// pin synchronisers
// ----------------------------------------
reg [1:0] sck_sync_reg;
reg [1:0] cs_sync_reg;
reg [1:0] si_sync_reg;
reg [1:0] wp_sync_reg;
reg sck_prev_reg;
always @(posedge clk_sys_in or negedge rst_b_in)
begin
    if (!rst_b_in)
    begin
        sck_sync_reg <= 2'h0;
        cs_sync_reg <= 2'h3;
        si_sync_reg <= 2'h0;
        wp_sync_reg <= 2'h3;
        sck_prev_reg <= 1'b0;
    end
    else
    begin
        sck_sync_reg <= {sck_sync_reg[0], sck_in};
        cs_sync_reg <= {cs_sync_reg[0], cs_b_in};
        si_sync_reg <= {si_sync_reg[0], si_in};
        wp_sync_reg <= {wp_sync_reg[0], wp_b_in};
        sck_prev_reg <= sck_sync_reg[1];
    end
end
wire sck_s = sck_sync_reg[1];
wire cs_act = ~cs_sync_reg[1];
wire wp_asserted = ~wp_sync_reg[1];
wire sck_rise = sck_s & ~sck_prev_reg & cs_act;
wire sck_fall = ~sck_s & sck_prev_reg & cs_act;
// ----------------------------------------
// state
// ----------------------------------------
reg cs_act_prev_reg;
reg [2:0] bit_cnt_reg;
reg [1:0] byte_cnt_reg;
reg [7:0] shift_in_reg;
reg [7:0] op_reg;
reg [7:0] wr_data_reg;
reg wr_data_ok_reg;
reg rd_mode_reg;
reg rd_byte_reg;
reg [2:0] rd_bit_reg;
reg lock_reg;
reg prot_reg;
reg err_reg;
reg wel_reg;
reg reset_command_enable_reg;
wire cs_end = cs_act_prev_reg & ~cs_act;
wire [7:0] shifted = {shift_in_reg[6:0], si_sync_reg[1]};
wire byte_done = sck_rise && (bit_cnt_reg == `FSR_BIT_LAST);
wire on_boundary = (bit_cnt_reg == `FSR_BITS_ZERO);
// ----------------------------------------
// live status bytes
// ----------------------------------------
reg [7:0] stat1;
reg [7:0] stat2;
always @*
begin
    stat1 = `FSR_BYTE_ZERO;
    stat1[`FSR_B1_LOCK] = lock_reg;
    stat1[`FSR_B1_ERR] = err_reg;
    stat1[`FSR_B1_PIN] = ~wp_asserted;
    stat1[`FSR_B1_PROT] = prot_reg;
    stat1[`FSR_B1_WEL] = wel_reg;
    stat1[`FSR_B1_BUSY] = op_busy_in;
    stat2 = `FSR_BYTE_ZERO;
    stat2[`FSR_B2_RESET_COMMAND_ENABLE] = reset_command_enable_reg;
    stat2[`FSR_B2_BUSY] = op_busy_in;
end
// live bytes are read per bit, so each pass is fresh
wire cur_bit = rd_byte_reg ? stat2[rd_bit_reg] : stat1[rd_bit_reg];
// ----------------------------------------
// write-status decisions
// ----------------------------------------
wire ws_ok = cs_end && wel_reg && wr_data_ok_reg && on_boundary;
wire lock_new = wr_data_reg[`FSR_B1_LOCK];
wire prot_new = wr_data_reg[`FSR_B1_PROT];
// pin asserted: clearing the lock ignores the whole write
wire ws_refuse = wp_asserted && lock_reg && !lock_new;
wire prot_frozen = wp_asserted && lock_reg;
wire is_ws = (op_reg == `FSR_OP_WR_STATUS);
wire is_ws2 = (op_reg == `FSR_OP_WR_STATUS2);
wire op_full = (byte_cnt_reg != `FSR_OPC_BYTE);
// ----------------------------------------
// serial engine
// ----------------------------------------
wire op_taken = byte_done && (byte_cnt_reg == `FSR_OPC_BYTE);
// answered regardless of busy state
wire rd_start = op_taken && (shifted == `FSR_OP_RD_STATUS);
wire rd_step = sck_fall && rd_mode_reg;
// ----------------------------------------
// select edge
// ----------------------------------------
// end of frame is flagged in the first cycle the synchronised pin reads high
always @(posedge clk_sys_in or negedge rst_b_in)
begin
    if (!rst_b_in)
        cs_act_prev_reg <= 1'b0;
    else
        cs_act_prev_reg <= cs_act;
end
// ----------------------------------------
// frame position
// ----------------------------------------
// counters restart on every select; 8 rises make one byte
always @(posedge clk_sys_in or negedge rst_b_in)
begin
    if (!rst_b_in)
    begin
        bit_cnt_reg <= `FSR_BITS_ZERO;
        byte_cnt_reg <= `FSR_OPC_BYTE;
    end
    else
    begin
        if (!cs_act)
        begin
            bit_cnt_reg <= `FSR_BITS_ZERO;
            byte_cnt_reg <= `FSR_OPC_BYTE;
        end
        else
        begin
            if (sck_rise)
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
            // byte count saturates: extra data bytes are ignored
            if (byte_done && byte_cnt_reg != `FSR_EXTRA_BYTE)
                byte_cnt_reg <= byte_cnt_reg + 2'h1;
        end
    end
end
// ----------------------------------------
// opcode and data capture
// ----------------------------------------
// shifter keeps filling; only the first two bytes are kept
always @(posedge clk_sys_in or negedge rst_b_in)
begin
    if (!rst_b_in)
    begin
        shift_in_reg <= `FSR_BYTE_ZERO;
        op_reg <= `FSR_BYTE_ZERO;
        wr_data_reg <= `FSR_BYTE_ZERO;
        wr_data_ok_reg <= 1'b0;
    end
    else
    begin
        if (!cs_act && !cs_act_prev_reg)
            wr_data_ok_reg <= 1'b0;
        if (sck_rise)
            shift_in_reg <= shifted;
        if (op_taken)
            op_reg <= shifted;
        if (byte_done && byte_cnt_reg == `FSR_DATA_BYTE)
        begin
            wr_data_reg <= shifted;
            wr_data_ok_reg <= 1'b1;
        end
    end
end
// ----------------------------------------
// opcode report
// ----------------------------------------
// one pulse per frame; later bytes never repeat it
always @(posedge clk_sys_in or negedge rst_b_in)
begin
    if (!rst_b_in)
    begin
        opcode_out <= 1'b0;
        opcode_val_out <= `FSR_BYTE_ZERO;
    end
    else
    begin
        opcode_out <= op_taken;
        if (op_taken)
            opcode_val_out <= shifted;
    end
end
// ----------------------------------------
// status read pointer
// ----------------------------------------
// walks byte 1 then byte 2, msb first, for as long as clocks come
always @(posedge clk_sys_in or negedge rst_b_in)
begin
    if (!rst_b_in)
    begin
        rd_mode_reg <= 1'b0;
        rd_byte_reg <= 1'b0;
        rd_bit_reg <= `FSR_BIT_LAST;
    end
    else if (!cs_act)
        rd_mode_reg <= 1'b0;
    else if (rd_start)
    begin
        rd_mode_reg <= 1'b1;
        rd_byte_reg <= 1'b0;
        rd_bit_reg <= `FSR_BIT_LAST;
    end
    else if (rd_step)
    begin
        if (rd_bit_reg == `FSR_BITS_ZERO)
        begin
            rd_bit_reg <= `FSR_BIT_LAST;
            rd_byte_reg <= ~rd_byte_reg;
        end
        else
            rd_bit_reg <= rd_bit_reg - 3'h1;
    end
end
// ----------------------------------------
// serial output
// ----------------------------------------
// moves only after a falling clock, so the host sees it settled
always @(posedge clk_sys_in or negedge rst_b_in)
begin
    if (!rst_b_in)
    begin
        so_out <= 1'b0;
        so_oe_out <= 1'b0;
    end
    else if (!cs_act)
        so_oe_out <= 1'b0;
    else if (rd_step)
    begin
        so_out <= cur_bit;
        so_oe_out <= 1'b1;
    end
end
// ----------------------------------------
// status bits
// ----------------------------------------
wire ws_apply = ws_ok && is_ws && !ws_refuse;
wire wel_cmd_seen = op_full && (is_ws || is_ws2 ||
    op_reg == `FSR_OP_WR_DISABLE);
// frame-end clears need a full opcode; partial opcodes keep latch
wire wel_clear = dev_reset_in || hold_abort_in || op_done_in
    || op_abort_in || (cs_end && wel_cmd_seen);
wire wel_set = cs_end && op_full && on_boundary
    && (op_reg == `FSR_OP_WR_ENABLE);
// protection lock: with the pin asserted it may only rise
always @(posedge clk_sys_in or negedge rst_b_in)
begin
    if (!rst_b_in)
        lock_reg <= 1'b0;
    else if (ws_apply)
        lock_reg <= lock_new;
end
// array protect keeps its old value while frozen
always @(posedge clk_sys_in or negedge rst_b_in)
begin
    if (!rst_b_in)
        prot_reg <= 1'b0;
    else if (ws_apply && !prot_frozen)
        prot_reg <= prot_new;
end
// error flag follows the result of each finished operation
always @(posedge clk_sys_in or negedge rst_b_in)
begin
    if (!rst_b_in)
        err_reg <= 1'b0;
    else if (op_done_in)
        err_reg <= op_fail_in;
end
// write latch: a set meeting a clear in one cycle wins
always @(posedge clk_sys_in or negedge rst_b_in)
begin
    if (!rst_b_in)
        wel_reg <= 1'b0;
    else if (wel_set)
        wel_reg <= 1'b1;
    else if (wel_clear)
        wel_reg <= 1'b0;
end
// reset command enable
always @(posedge clk_sys_in or negedge rst_b_in)
begin
    if (!rst_b_in)
        reset_command_enable_reg <= 1'b0;
    else if (ws_ok && is_ws2)
        reset_command_enable_reg <= wr_data_reg[`FSR_B2_RESET_COMMAND_ENABLE];
end
// ----------------------------------------
// registered copies for the rest of the device
// ----------------------------------------
always @(posedge clk_sys_in or negedge rst_b_in)
begin
    if (!rst_b_in)
    begin
        array_protect_out <= 1'b0;
        write_enable_latch_out <= 1'b0;
        reset_command_enable_out <= 1'b0;
    end
    else
    begin
        array_protect_out <= prot_reg;
        write_enable_latch_out <= wel_reg;
        reset_command_enable_out <= reset_command_enable_reg;
    end
end
endmodule

// ==== tb/fsr_status_sva.sv ====
`timescale 1ns/100ps
module fsr_status_sva (
    input wire clk_sys_in, rst_b_in, sck_in, cs_b_in,
    input wire op_done_in, op_abort_in, dev_reset_in, hold_abort_in,
    input wire so_out, so_oe_out, array_protect_out,
    input wire write_enable_latch_out, reset_command_enable_out,
    input wire [7:0] opcode_val_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);
    oe_start_a: assert property (
        $rose(so_oe_out) |-> opcode_val_out == 8'h05)
        else $error("output enabled without status read");
    oe_drop_a: assert property (
        cs_b_in [*8] |-> !so_oe_out)
        else $error("output still driven after deselect");
    so_edge_a: assert property (
        $changed(so_out) |-> !sck_in)
        else $error("serial output moved while clock high");
    wel_reset_a: assert property (
        dev_reset_in |-> ##[1:3] !write_enable_latch_out)
        else $error("latch kept over device reset");
    wel_hold_a: assert property (
        hold_abort_in |-> ##[1:3] !write_enable_latch_out)
        else $error("latch kept over hold abort");
    wel_op_a: assert property (
        (op_done_in || op_abort_in) |-> ##[1:3] !write_enable_latch_out)
        else $error("latch kept after operation end");
    prot_gate_a: assert property (
        $changed(array_protect_out) |-> $past(write_enable_latch_out))
        else $error("protect changed with latch clear");
    prot_cs_a: assert property (
        $changed(array_protect_out) |-> cs_b_in)
        else $error("protect changed inside a frame");
    reset_command_enable_gate_a: assert property (
        $changed(reset_command_enable_out) |-> $past(write_enable_latch_out))
        else $error("reset enable changed with latch clear");
    cover property ($rose(write_enable_latch_out));
    cover property ($rose(so_oe_out));
    cover property ($changed(array_protect_out));
endmodule

// ==== tb/fsr_host.sv ====
`timescale 1ns/100ps
module fsr_host #(
    parameter HALF = 24
) (
    output reg sck_out,  // serial clock, idle low
    output reg cs_b_out, // chip select, active low
    output reg si_out,   // data to device
    input wire so_in     // data from device
);
    initial
    begin
        sck_out = 1'b0;
        cs_b_out = 1'b1;
        si_out = 1'b0;
    end
    // n bits msb first; n off a byte boundary cuts the frame short
    task xfer(input [31:0] tx, input integer n, output [31:0] rx);
        integer i;
        begin
            rx = 32'h0000_0000;
            cs_b_out = 1'b0;
            for (i = 0; i < n; i = i + 1)
            begin
                si_out = tx[31 - i];
                #HALF sck_out = 1'b1;
                rx[31 - i] = so_in;
                #HALF sck_out = 1'b0;
            end
            #HALF cs_b_out = 1'b1;
            si_out = ~si_out;
            #100;
        end
    endtask
endmodule

// ==== tb/fsr_status_tb_top.sv ====
`timescale 1ns/100ps
module fsr_status_tb_top;
    reg clk_sys_in = 1'b0;
    reg rst_b_in = 1'b0;
    reg wp_b_in = 1'b1;
    reg op_busy_in = 1'b0;
    reg op_done_in = 1'b0;
    reg op_fail_in = 1'b0;
    reg op_abort_in = 1'b0;
    reg dev_reset_in = 1'b0;
    reg hold_abort_in = 1'b0;
    wire sck_in, cs_b_in, si_in, so_out, so_oe_out, opcode_out;
    wire array_protect_out, write_enable_latch_out;
    wire reset_command_enable_out;
    wire [7:0] opcode_val_out;
    wire so_w = so_oe_out ? so_out : 1'bz;
    reg [31:0] rx;
    integer err_count = 0;
    integer checked = 0;
    integer op_seen = 0;
    always @(posedge clk_sys_in)
        if (opcode_out === 1'b1)
            op_seen <= op_seen + 1;
    always #2.5 clk_sys_in = ~clk_sys_in;
    fsr_status fsr_status_i (.*);
    fsr_host fsr_host_i (.sck_out(sck_in), .cs_b_out(cs_b_in),
        .si_out(si_in), .so_in(so_w));
    task chk(input [63:0] nm, input [7:0] got, input [7:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp)
            begin
                err_count = err_count + 1;
                $display("[FAIL] %0s exp %h got %h", nm, exp, got);
            end
        end
    endtask
    task ev(input [4:0] v);
        begin
            @(negedge clk_sys_in);
            {hold_abort_in, dev_reset_in, op_abort_in, op_fail_in,
                op_done_in} = v;
            @(negedge clk_sys_in);
            {hold_abort_in, dev_reset_in, op_abort_in, op_fail_in,
                op_done_in} = 5'h00;
            repeat (4) @(negedge clk_sys_in);
        end
    endtask
    task cmd(input [7:0] op, input [7:0] d, input integer n);
        fsr_host_i.xfer({op, d, 16'h0000}, n, rx);
    endtask
    task rd(input [7:0] e1, input [7:0] e2);
        begin
            cmd(8'h05, 8'h00, 32);
            chk("byte1", rx[23:16], e1);
            chk("byte2", rx[15:8], e2);
            chk("wrap", rx[7:0], e1);
        end
    endtask
    task t_write;
        begin
            rd(8'h10, 8'h00);
            cmd(8'h06, 8'h00, 8);
            rd(8'h12, 8'h00);
            cmd(8'h01, 8'h84, 16);
            rd(8'h94, 8'h00);
            cmd(8'h06, 8'h00, 8);
            cmd(8'h01, 8'h7B, 16);
            rd(8'h10, 8'h00);
            cmd(8'h06, 8'h00, 8);
            cmd(8'h01, 8'h84, 16);
            chk("prot", {7'h00, array_protect_out}, 8'h01);
        end
    endtask
    task t_lock;
        begin
            @(negedge clk_sys_in) wp_b_in = 1'b0;
            cmd(8'h06, 8'h00, 8);
            cmd(8'h01, 8'h00, 16);
            rd(8'h84, 8'h00);
            cmd(8'h06, 8'h00, 8);
            cmd(8'h01, 8'h80, 16);
            rd(8'h84, 8'h00);
            @(negedge clk_sys_in) wp_b_in = 1'b1;
            cmd(8'h01, 8'h00, 16);
            rd(8'h94, 8'h00);
        end
    endtask
    task t_wel;
        begin
            cmd(8'h06, 8'h00, 8);
            cmd(8'h01, 8'h00, 4);
            cmd(8'hA5, 8'h00, 8);
            rd(8'h96, 8'h00);
            ev(5'h08);
            rd(8'h94, 8'h00);
            cmd(8'h06, 8'h00, 8);
            ev(5'h10);
            rd(8'h94, 8'h00);
            cmd(8'h06, 8'h00, 8);
            cmd(8'h31, 8'h10, 16);
            chk("reset_command_enable", {7'h00, reset_command_enable_out}, 8'h01);
        end
    endtask
    task t_busy;
        begin
            fork
                cmd(8'h05, 8'h00, 32);
                #900 @(negedge clk_sys_in) op_busy_in = 1'b1;
            join
            chk("busy1", rx[23:16], 8'h94);
            chk("busy2", rx[15:8], 8'h11);
            chk("fresh", rx[7:0], 8'h95);
            cmd(8'h06, 8'h00, 8);
            ev(5'h03);
            @(negedge clk_sys_in) op_busy_in = 1'b0;
            rd(8'hB4, 8'h10);
            cmd(8'h06, 8'h00, 8);
            ev(5'h04);
            rd(8'hB4, 8'h10);
            ev(5'h01);
            rd(8'h94, 8'h10);
            cmd(8'h05, 8'h00, 13);
            chk("oe", {7'h00, so_oe_out}, 8'h00);
        end
    endtask
    task print_verdict;
        begin
            if (err_count == 0 && checked > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    initial
    begin
        repeat (5) @(negedge clk_sys_in);
        rst_b_in = 1'b1;
        repeat (5) @(negedge clk_sys_in);
        t_write;
        t_lock;
        t_wel;
        t_busy;
        chk("opcodes", op_seen[7:0], 8'h21);
        print_verdict;
    end
    // frames take up to about 1.7 us each; far beyond that means a hang
    initial
    begin
        #300000;
        err_count = err_count + 1;
        print_verdict;
    end
endmodule
bind fsr_status fsr_status_sva fsr_status_sva_i (.*);
